/* File: rtc_hour_minute.v */
// Hour and minute BCD value registers with carry chain
`timescale 1ns/100ps
`include "rtc_hm_map.vh"
module rtc_hour_minute (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire minute_tick_i,
    output reg [7:0] rdata_o,
    output reg day_carry_o,
    output reg clock_write_unlock_o
);
    // ==========================================================
    // Digit widths
    localparam ONES_W = 4;
    localparam MIN_TENS_W = 3;
    localparam HOUR_TENS_W = 2;

    // ==========================================================
    // Helper functions
    // Address compare shared by the three write decodes; the read side
    // decodes with its own case on addr_i, not through this function
    function addr_hit;
        input [3:0] addr;
        input [3:0] ofs;
        begin
            addr_hit = (addr == ofs);
        end
    endfunction

    // Hour image: bits 7-6 are unimplemented and read as zero
    function [7:0] pack_hour;
        input [1:0] tens;
        input [3:0] ones;
        begin
            pack_hour = {2'b00, tens, ones}; // [RULE_01]
        end
    endfunction

    // Minute image: bit 7 is unimplemented and reads as zero
    function [7:0] pack_minute;
        input [2:0] tens;
        input [3:0] ones;
        begin
            pack_minute = {1'b0, tens, ones}; // [RULE_04]
        end
    endfunction

    // Control image: only the unlock bit is implemented
    function [7:0] pack_ctrl;
        input unlock;
        begin
            pack_ctrl = {7'h00, unlock};
        end
    endfunction

    // Hour ones limit: 3 when tens is at its top (23 -> 00), else 9
    function [3:0] hour_ones_limit;
        input [1:0] tens;
        begin
            if ({2'b00, tens} == `HOUR_TENS_MAX) begin
                hour_ones_limit = `HOUR_ONES_AT_MAX;
            end else begin
                hour_ones_limit = `ONES_MAX;
            end
        end
    endfunction

    // ==========================================================
    // Control register
    // Cleared on reset so a stray write after power-up cannot reach the
    // hour digits before software has opened the lock on purpose
    wire ctrl_wr;
    reg unlock_d;
    reg unlock_q;
    assign ctrl_wr = wr_i && addr_hit(addr_i, `CTRL_OFS);
    always @* begin
        unlock_d = unlock_q;
        if (ctrl_wr) begin
            unlock_d = wdata_i[`CTRL_UNLOCK_BIT];
        end
    end
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            unlock_q <= `CTRL_UNLOCK_RESET;
        end else begin
            unlock_q <= unlock_d;
        end
    end

    // ==========================================================
    // Write decode
    wire hour_sel;
    wire min_sel;
    wire hour_wr;
    wire min_wr;
    assign hour_sel = wr_i && addr_hit(addr_i, `HOUR_BCD_OFS);
    assign min_sel = wr_i && addr_hit(addr_i, `MINUTE_BCD_OFS);
    // A locked hour write dies here and never reaches the digits
    assign hour_wr = hour_sel && unlock_q; // [RULE_03]
    assign min_wr = min_sel;

    // ==========================================================
    // Minute tick qualification
    // The tick comes from logic on this clock, so it needs no synchroniser
    // An hour or minute write in the tick cycle wins and that tick is lost;
    // software should hold the tick off while it sets the time
    wire any_time_wr;
    wire min_ones_inc;
    assign any_time_wr = hour_wr || min_wr;
    assign min_ones_inc = minute_tick_i && !any_time_wr;

    // ==========================================================
    // Digits and carry chain
    wire [3:0] min_ones;
    wire [2:0] min_tens;
    wire [3:0] hour_ones;
    wire [1:0] hour_tens;
    wire min_ones_wrap;
    wire min_tens_wrap;
    wire hour_ones_wrap;
    wire hour_tens_wrap;
    wire [3:0] hour_ones_max;
    // Hour ones wraps at 3 only when tens is at its top, giving 23 -> 00
    assign hour_ones_max = hour_ones_limit(hour_tens); // [RULE_07]
    // Each digit wraps on a >= compare, so a digit written out of range
    // falls back to zero on its next step instead of running away

    bcd_digit #(.W(ONES_W)) u_min_ones (
        .sys_clk_i(sys_clk_i),
        .load_i(min_wr),
        .load_val_i(wdata_i[`ONES_MSB:`ONES_LSB]), // [RULE_05]
        .inc_i(min_ones_inc),
        .max_i(`ONES_MAX),
        .wrap_o(min_ones_wrap),
        .digit_o(min_ones)
    );
    bcd_digit #(.W(MIN_TENS_W)) u_min_tens (
        .sys_clk_i(sys_clk_i),
        .load_i(min_wr),
        .load_val_i(wdata_i[`MIN_TENS_MSB:`MIN_TENS_LSB]), // [RULE_04]
        .inc_i(min_ones_wrap),
        .max_i(`MIN_TENS_MAX),
        .wrap_o(min_tens_wrap),
        .digit_o(min_tens)
    );
    bcd_digit #(.W(ONES_W)) u_hour_ones (
        .sys_clk_i(sys_clk_i),
        .load_i(hour_wr),
        .load_val_i(wdata_i[`ONES_MSB:`ONES_LSB]), // [RULE_02]
        .inc_i(min_tens_wrap), // [RULE_07]
        .max_i(hour_ones_max),
        .wrap_o(hour_ones_wrap),
        .digit_o(hour_ones)
    );
    bcd_digit #(.W(HOUR_TENS_W)) u_hour_tens (
        .sys_clk_i(sys_clk_i),
        .load_i(hour_wr),
        .load_val_i(wdata_i[`HOUR_TENS_MSB:`HOUR_TENS_LSB]), // [RULE_01]
        .inc_i(hour_ones_wrap),
        .max_i(`HOUR_TENS_MAX),
        .wrap_o(hour_tens_wrap),
        .digit_o(hour_tens)
    );

    // ==========================================================
    // Read port and outputs
    reg [7:0] rdata_d;
    reg day_carry_d;
    reg unlock_out_d;
    // Read data are forced to zero outside the cycle after a read, so
    // the bus can OR several slaves together without a select
    always @* begin
        rdata_d = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `HOUR_BCD_OFS: begin
                    rdata_d = pack_hour(hour_tens, hour_ones);
                end
                `MINUTE_BCD_OFS: begin
                    rdata_d = pack_minute(min_tens, min_ones);
                end
                `CTRL_OFS: begin
                    rdata_d = pack_ctrl(unlock_q);
                end
                default: begin
                    rdata_d = 8'h00;
                end
            endcase
        end
    end

    // ==========================================================
    // Carry and unlock next values
    // Outputs come straight from flip-flops, at the cost of one cycle
    // of delay on the day carry and on the visible unlock level
    always @* begin
        day_carry_d = hour_tens_wrap; // [RULE_07]
        unlock_out_d = unlock_q;
    end

    // ==========================================================
    // Output registers
    always @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rdata_o <= `RDATA_RESET;
            day_carry_o <= 1'b0;
            clock_write_unlock_o <= `CTRL_UNLOCK_RESET;
        end else begin
            rdata_o <= rdata_d;
            day_carry_o <= day_carry_d;
            clock_write_unlock_o <= unlock_out_d;
        end
    end
endmodule // rtc_hour_minute

/* File: rtc_hm_map.vh */
// Register map and field constants for the hour and minute registers
// What this block does
// RULE_01 - Hour tens BCD bits 5-4, 0-2; 7-6 zero
// RULE_02 - Hour ones BCD bits 3-0, 0-9
// RULE_03 - Hour writes only when unlock is 1
// RULE_04 - Minute tens BCD bits 6-4, 0-5; 7 zero
// RULE_05 - Minute ones BCD bits 3-0, 0-9
// RULE_06 - Digit bits read/write, no fixed reset
// RULE_07 - Minutes wrap 59 to 00, hours 23 to 00
`ifndef RTC_HM_MAP_VH
`define RTC_HM_MAP_VH
// ==========================================================
// Offsets
`define HOUR_BCD_OFS 4'h0
`define MINUTE_BCD_OFS 4'h1
`define CTRL_OFS 4'h2
// ==========================================================
// Fields
`define HOUR_TENS_MSB 5
`define HOUR_TENS_LSB 4
`define MIN_TENS_MSB 6
`define MIN_TENS_LSB 4
`define ONES_MSB 3
`define ONES_LSB 0
`define HOUR_TENS_MAX 4'h2
`define HOUR_ONES_AT_MAX 4'h3
`define MIN_TENS_MAX 4'h5
`define ONES_MAX 4'h9
`define CTRL_UNLOCK_BIT 0
`define CTRL_RESET 8'h00
`define CTRL_UNLOCK_RESET 1'b0
`define RDATA_RESET 8'h00
`endif

/* File: bcd_digit.v */
// One BCD digit with load and wrap-around increment
`timescale 1ns/100ps
module bcd_digit #(
    parameter W = 4
) (
    input wire sys_clk_i,
    input wire load_i,
    input wire [W-1:0] load_val_i,
    input wire inc_i,
    input wire [3:0] max_i,
    output wire wrap_o,
    output reg [W-1:0] digit_o
);
    // ==========================================================
    // Digit storage
    // No reset: power-on value is left undefined on purpose
    reg [3:0] digit_ext;
    // Widened by hand: narrow tens digits meet a four-bit limit, and a
    // zero-width replication would not be legal for the ones digit
    always @* begin
        digit_ext = 4'h0;
        digit_ext[W-1:0] = digit_o;
    end
    assign wrap_o = inc_i && (digit_ext >= max_i); // [RULE_07]
    always @(posedge sys_clk_i) begin
        if (load_i) begin
            digit_o <= load_val_i; // [RULE_06]
        end else if (inc_i) begin
            if (wrap_o) begin
                digit_o <= {W{1'b0}}; // [RULE_07]
            end else begin
                digit_o <= digit_o + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule // bcd_digit

/* File: rtc_hour_minute_assertions.sv */
// Port checker for the hour and minute registers
`timescale 1ns/100ps
module rtc_hour_minute_assertions (
    input wire sys_clk_i,
    input wire rstn_i,
    input wire [3:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire minute_tick_i,
    input wire [7:0] rdata_o,
    input wire day_carry_o,
    input wire clock_write_unlock_o
);
    // ====
    // Checks
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_rdata_idle: assert property (
        !$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data without read");
    a_hour_top: assert property (
        $past(rd_i && addr_i == 4'h0) |-> rdata_o[7:6] == 2'b00)
        else $error("hour top bits set");
    a_minute_top: assert property (
        $past(rd_i && addr_i == 4'h1) |-> !rdata_o[7])
        else $error("minute top bit set");
    a_unmapped_zero: assert property (
        $past(rd_i && addr_i > 4'h2) |-> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    // The visible unlock level trails the control write by two edges
    a_unlock_load: assert property (
        $past(wr_i && addr_i == 4'h2, 2) |->
        clock_write_unlock_o == $past(wdata_i[0], 2))
        else $error("unlock not loaded");
    a_unlock_hold: assert property (
        !$past(wr_i && addr_i == 4'h2, 2) |->
        $stable(clock_write_unlock_o))
        else $error("unlock changed");
    a_carry_pulse: assert property (
        day_carry_o |=> !day_carry_o)
        else $error("day carry too long");
    a_carry_cause: assert property (
        day_carry_o |-> $past(minute_tick_i))
        else $error("day carry without tick");
endmodule // rtc_hour_minute_assertions

/* File: test_rtc_hour_minute.sv */
// Directed test of the hour and minute registers
`timescale 1ns/100ps
module test_rtc_hour_minute;
    reg clk = 0, rstn = 0, wr = 0, rd = 0, tick = 0;
    reg [3:0] addr = 4'h0;
    reg [7:0] wdata = 8'h00;
    wire [7:0] rdata;
    wire carry, unlock;
    integer n_mismatch = 0, comparisons = 0;
    always #10 clk = ~clk;
    rtc_hour_minute u_rtc_hour_minute (.sys_clk_i(clk), .rstn_i(rstn),
        .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
        .minute_tick_i(tick), .rdata_o(rdata), .day_carry_o(carry),
        .clock_write_unlock_o(unlock));
    // ====
    // Bus tasks
    task chk(input string n, input [7:0] e, input [7:0] s);
        begin
            comparisons = comparisons + 1;
            if (s !== e) begin
                n_mismatch = n_mismatch + 1;
                $display("unexpected %s expected %h seen %h", n, e, s);
            end
        end
    endtask
    task wrt(input [3:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge clk);
            wr <= 1'b0;
        end
    endtask
    // Read data stand one cycle only, so sample just after the edge
    task rdc(input [3:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            rd <= 1'b1;
            @(posedge clk);
            rd <= 1'b0;
            #1 chk("rdata_o", e, rdata);
        end
    endtask
    task tk(input e);
        begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            // Carry stands only in the cycle after the tick edge
            #1 chk("day_carry_o", {7'h00, e}, {7'h00, carry});
        end
    endtask
    task finish_test;
        begin
            if (n_mismatch == 0 && comparisons > 0) $display("Test passed");
            else $display("Test failed");
            $finish;
        end
    endtask
    // ====
    // Tests
    initial begin
        #20000 n_mismatch = n_mismatch + 1;
        finish_test;
    end
    // Digits have no reset value, so each is written before it is read
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        wrt(4'h2, 8'h01);
        rdc(4'h2, 8'h01);
        chk("clock_write_unlock_o", 8'h01, {7'h00, unlock});
        wrt(4'h0, 8'h23);
        wrt(4'h1, 8'h59);
        rdc(4'h0, 8'h23);
        rdc(4'h1, 8'h59);
        tk(1'b1);
        rdc(4'h0, 8'h00);
        rdc(4'h1, 8'h00);
        wrt(4'h0, 8'h09);
        wrt(4'h1, 8'h59);
        tk(1'b0);
        rdc(4'h0, 8'h10);
        wrt(4'h0, 8'hff);
        rdc(4'h0, 8'h3f);
        wrt(4'h1, 8'hff);
        rdc(4'h1, 8'h7f);
        wrt(4'h2, 8'h00);
        wrt(4'h0, 8'h12);
        rdc(4'h0, 8'h3f);
        chk("clock_write_unlock_o", 8'h00, {7'h00, unlock});
        wrt(4'h1, 8'h45);
        rdc(4'h1, 8'h45);
        rdc(4'hf, 8'h00);
        finish_test;
    end
endmodule // test_rtc_hour_minute
bind rtc_hour_minute rtc_hour_minute_assertions
    u_rtc_hour_minute_assertions (.*);
